// file: verilog/eqac_pkg.sv
package eqac_pkg;

  localparam int LOOPS = 21;
  localparam int FIRST_LOOPS = 17;
  localparam int VAL_W = 8;
  localparam int CFG_W = 16;
  localparam int SYNC_W = 2 * LOOPS + 2;
  localparam logic [VAL_W-1:0] LOOP_INIT = 8'h00;
  localparam logic [VAL_W-1:0] ABSENT_VALUE = 8'h00;
  localparam logic SEL_FEEDBACK = 1'h0;
  localparam logic SEL_LINEAR = 1'h1;
  localparam int WORD_THIRD = 2;
  localparam int WORD_SECOND = 1;

  // Loop order: offset, linear low, linear high, gain, feedback low,
  // threshold, peak, then coefficients 2 to 15
  localparam int FIRST_HI [LOOPS] = '{15, 15, 13, 6, 15, 15, 15, 14, 14,
    13, 13, 13, 13, 13, 13, 13, 13, 13, 13, 13, 13};
  localparam int FIRST_LO [LOOPS] = '{9, 11, 9, 2, 11, 9, 9, 9, 9,
    9, 9, 9, 9, 9, 9, 9, 9, 9, 9, 9, 9};
  localparam int FIRST_WORD [LOOPS] = '{0, 0, 0, 2, 0, 0, 0, 0, 0,
    0, 0, 0, 0, 0, 0, 0, 0, 0, 0, 0, 0};
  localparam int LATER_HI [LOOPS] = '{15, 13, 13, 15, 15, 15, 15, 15, 15,
    15, 15, 15, 15, 15, 15, 15, 15, 13, 13, 13, 13};
  localparam int LATER_LO [LOOPS] = '{9, 9, 9, 11, 11, 8, 9, 10, 10,
    11, 11, 11, 11, 11, 11, 11, 11, 9, 9, 9, 9};
  localparam int LATER_WORD [LOOPS] = '{1, 1, 1, 1, 1, 1, 1, 1, 1,
    1, 1, 1, 1, 1, 1, 1, 1, 0, 0, 0, 0};
  // Both low-frequency loops read the one shared word pair
  localparam int WORD_SRC [LOOPS] = '{0, 1, 2, 3, 1, 5, 6, 7, 8,
    9, 10, 11, 12, 13, 14, 15, 16, 17, 18, 19, 20};
  localparam logic [LOOPS-1:0] LINEAR_PATH = 21'h000006;

  typedef enum logic [2:0] {
    EQAC_ADAPT = 3'h1,
    EQAC_FREEZE = 3'h2,
    EQAC_FORCE = 3'h4
  } eqac_mode_t;

  typedef enum logic [2:0] {
    EQAC_ST_CLEAR = 3'h1,
    EQAC_ST_FEEDBACK = 3'h2,
    EQAC_ST_LINEAR = 3'h4
  } eqac_state_t;

  typedef logic [CFG_W-1:0] eqac_word_t;
  typedef logic [VAL_W-1:0] eqac_value_t;

endpackage

// file: verilog/eqac_loop_if.sv
`timescale 1ns/10ps
`default_nettype none
interface eqac_loop_if;
  import eqac_pkg::*;
  logic clear;
  eqac_mode_t mode;
  logic step;
  logic up;
  eqac_value_t force_value;
  eqac_value_t value;
  modport ctrl (output clear, mode, step, up, force_value, input value);
  modport loop (input clear, mode, step, up, force_value, output value);
endinterface
`default_nettype wire

// file: verilog/eqac_sync.sv
`timescale 1ns/10ps
`default_nettype none
module eqac_sync #(
  parameter int WIDTH = 2
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic ce,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] next_stage1;
  logic [WIDTH-1:0] next_sync_out;

  always_comb begin
    next_stage1 = ce ? async_in : stage1;
    next_sync_out = ce ? stage1 : sync_out;
  end

  // First stage feeds the second stage only
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      stage1 <= '0;
      sync_out <= '0;
    end else begin
      stage1 <= next_stage1;
      sync_out <= next_sync_out;
    end
  end
endmodule
`default_nettype wire

// file: verilog/eqac_loop.sv
`timescale 1ns/10ps
`default_nettype none
module eqac_loop
  import eqac_pkg::*;
#(
  parameter int WIDTH = 5
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic ce,
  eqac_loop_if.loop bus
);
  localparam logic [WIDTH-1:0] TOP = '1;
  logic [WIDTH-1:0] acc;
  logic [WIDTH-1:0] next_acc;

  always_comb begin
    next_acc = acc;
    if (ce) begin
      if (bus.clear) begin
        next_acc = LOOP_INIT[WIDTH-1:0];
      end else begin
        case (bus.mode)
          EQAC_FORCE: next_acc = bus.force_value[WIDTH-1:0];
          EQAC_FREEZE: next_acc = acc;
          EQAC_ADAPT: begin
            // Saturate rather than wrap; a wrap would swing the filter
            if (bus.step && bus.up && acc != TOP) begin
              next_acc = acc + 1'b1;
            end else if (bus.step && !bus.up && acc != '0) begin
              next_acc = acc - 1'b1;
            end
          end
          default: next_acc = acc;
        endcase
      end
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      acc <= LOOP_INIT[WIDTH-1:0];
    end else begin
      acc <= next_acc;
    end
  end

  assign bus.value = VAL_W'(acc);
endmodule
`default_nettype wire

// file: verilog/eqac_top.sv
// Operation
// - Select 0 runs the feedback datapath, select 1 the linear datapath.
// - Adaptation reset clears both datapaths and restarts all adaptation.
// - Pair 00 adapts, 10 holds, x1 loads the configured override value.
// - Forced offset takes word bits 15:9, first word or second word.
// - Forced linear low gain takes 15:11 of word0, or 13:9 of word1.
// - Forced linear high gain takes 13:9 of word0, or of word1.
// - Forced gain control takes 6:2 of third word, or 15:11 of second.
// - Forced feedback low gain takes 15:11 of shared word0 or word1.
// - Forced threshold takes 15:9 of word0, or 15:8 of word1.
// - Forced peak takes 15:9 of word0, or of word1.
// - Forced coefficients 2, 3 take 14:9 of word0, or 15:10 of word1.
// - Forced coefficients 4 to 11 take 13:9 word0, or 15:11 word1.
// - Coefficients 12 to 15 exist on later variant only; 13:9 of word0.
`timescale 1ns/10ps
`default_nettype none
module eqac_top
  import eqac_pkg::*;
#(
  parameter bit LATER_VARIANT = 1'b1
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic ce,
  input wire logic equalizer_type_select,
  input wire logic equalizer_adapt_reset,
  input wire logic offset_loop_freeze,
  input wire logic offset_loop_force,
  input wire logic linear_lowfreq_freeze,
  input wire logic linear_lowfreq_force,
  input wire logic linear_highfreq_freeze,
  input wire logic linear_highfreq_force,
  input wire logic feedback_gain_freeze,
  input wire logic feedback_gain_force,
  input wire logic feedback_lowfreq_freeze,
  input wire logic feedback_lowfreq_force,
  input wire logic threshold_loop_freeze,
  input wire logic threshold_loop_force,
  input wire logic peak_loop_freeze,
  input wire logic peak_loop_force,
  input wire logic coeff2_freeze,
  input wire logic coeff2_force,
  input wire logic coeff3_freeze,
  input wire logic coeff3_force,
  input wire logic coeff4_freeze,
  input wire logic coeff4_force,
  input wire logic coeff5_freeze,
  input wire logic coeff5_force,
  input wire logic coeff6_freeze,
  input wire logic coeff6_force,
  input wire logic coeff7_freeze,
  input wire logic coeff7_force,
  input wire logic coeff8_freeze,
  input wire logic coeff8_force,
  input wire logic coeff9_freeze,
  input wire logic coeff9_force,
  input wire logic coeff10_freeze,
  input wire logic coeff10_force,
  input wire logic coeff11_freeze,
  input wire logic coeff11_force,
  input wire logic coeff12_freeze,
  input wire logic coeff12_force,
  input wire logic coeff13_freeze,
  input wire logic coeff13_force,
  input wire logic coeff14_freeze,
  input wire logic coeff14_force,
  input wire logic coeff15_freeze,
  input wire logic coeff15_force,
  input wire eqac_pkg::eqac_word_t cfg_word0 [eqac_pkg::LOOPS],
  input wire eqac_pkg::eqac_word_t cfg_word1 [eqac_pkg::LOOPS],
  input wire eqac_pkg::eqac_word_t gain_cfg_word2,
  input wire logic adapt_strobe,
  input wire logic [eqac_pkg::LOOPS-1:0] adapt_up,
  output eqac_pkg::eqac_value_t loop_value [eqac_pkg::LOOPS],
  output logic linear_path_active,
  output logic adapt_clearing,
  output logic restart_pending
);
  import eqac_pkg::*;

  function automatic eqac_mode_t pair_mode(input logic freeze,
                                           input logic force_en);
    if (force_en) begin
      pair_mode = EQAC_FORCE;
    end else if (freeze) begin
      pair_mode = EQAC_FREEZE;
    end else begin
      pair_mode = EQAC_ADAPT;
    end
  endfunction

  function automatic eqac_value_t pick_field(input eqac_word_t word,
                                             input int hi,
                                             input int lo);
    eqac_word_t shifted;
    eqac_word_t mask;
    shifted = word >> lo;
    mask = 16'hFFFF >> (15 - (hi - lo));
    pick_field = VAL_W'(shifted & mask);
  endfunction

  logic [LOOPS-1:0] freeze_raw;
  logic [LOOPS-1:0] force_raw;
  logic [LOOPS-1:0] freeze_s;
  logic [LOOPS-1:0] force_s;
  logic select_s;
  logic reset_s;
  logic [SYNC_W-1:0] sync_bus;

  assign freeze_raw = {coeff15_freeze, coeff14_freeze, coeff13_freeze,
    coeff12_freeze, coeff11_freeze, coeff10_freeze, coeff9_freeze,
    coeff8_freeze, coeff7_freeze, coeff6_freeze, coeff5_freeze,
    coeff4_freeze, coeff3_freeze, coeff2_freeze, peak_loop_freeze,
    threshold_loop_freeze, feedback_lowfreq_freeze, feedback_gain_freeze,
    linear_highfreq_freeze, linear_lowfreq_freeze, offset_loop_freeze};
  assign force_raw = {coeff15_force, coeff14_force, coeff13_force,
    coeff12_force, coeff11_force, coeff10_force, coeff9_force,
    coeff8_force, coeff7_force, coeff6_force, coeff5_force,
    coeff4_force, coeff3_force, coeff2_force, peak_loop_force,
    threshold_loop_force, feedback_lowfreq_force, feedback_gain_force,
    linear_highfreq_force, linear_lowfreq_force, offset_loop_force};

  eqac_sync #(
    .WIDTH(SYNC_W)
  ) u_sync (
    .clock(clock),
    .rst(rst),
    .ce(ce),
    .async_in({equalizer_type_select, equalizer_adapt_reset, freeze_raw,
      force_raw}),
    .sync_out(sync_bus)
  );

  assign select_s = sync_bus[SYNC_W-1];
  assign reset_s = sync_bus[SYNC_W-2];
  assign freeze_s = sync_bus[2*LOOPS-1:LOOPS];
  assign force_s = sync_bus[LOOPS-1:0];

  eqac_state_t state;
  eqac_state_t next_state;
  logic pending;
  logic next_pending;

  // A select change without a reset keeps adapting on stale state,
  // so it is flagged until the controller pulses the reset
  always_comb begin
    next_state = state;
    next_pending = pending;
    if (ce) begin
      if (reset_s) begin
        next_state = EQAC_ST_CLEAR;
        next_pending = 1'b0;
      end else begin
        case (state)
          EQAC_ST_CLEAR: begin
            next_state = (select_s == SEL_LINEAR) ? EQAC_ST_LINEAR
                                                  : EQAC_ST_FEEDBACK;
          end
          EQAC_ST_FEEDBACK: begin
            if (select_s == SEL_LINEAR) begin
              next_state = EQAC_ST_LINEAR;
              next_pending = 1'b1;
            end
          end
          EQAC_ST_LINEAR: begin
            if (select_s == SEL_FEEDBACK) begin
              next_state = EQAC_ST_FEEDBACK;
              next_pending = 1'b1;
            end
          end
          default: next_state = EQAC_ST_CLEAR;
        endcase
      end
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state <= EQAC_ST_CLEAR;
      pending <= 1'b0;
    end else begin
      state <= next_state;
      pending <= next_pending;
    end
  end

  assign linear_path_active = (state == EQAC_ST_LINEAR);
  assign adapt_clearing = (state == EQAC_ST_CLEAR);
  assign restart_pending = pending;

  eqac_loop_if lif [LOOPS] ();

  for (genvar i = 0; i < LOOPS; i++) begin : g_loop
    localparam bit PRESENT = LATER_VARIANT || (i < FIRST_LOOPS);
    localparam int HI = LATER_VARIANT ? LATER_HI[i] : FIRST_HI[i];
    localparam int LO = LATER_VARIANT ? LATER_LO[i] : FIRST_LO[i];
    localparam int WSEL = LATER_VARIANT ? LATER_WORD[i] : FIRST_WORD[i];
    localparam int WIDTH = HI - LO + 1;
    localparam logic ON_LINEAR = LINEAR_PATH[i];
    eqac_word_t word;
    logic path_live;

    always_comb begin
      if (WSEL == WORD_THIRD) begin
        word = gain_cfg_word2;
      end else if (WSEL == WORD_SECOND) begin
        word = cfg_word1[WORD_SRC[i]];
      end else begin
        word = cfg_word0[WORD_SRC[i]];
      end
    end

    // Loops of the idle path keep their value for a later switch back
    assign path_live = ON_LINEAR ? (state == EQAC_ST_LINEAR)
                                 : (state == EQAC_ST_FEEDBACK);
    assign lif[i].clear = (state == EQAC_ST_CLEAR);
    assign lif[i].mode = PRESENT ? pair_mode(freeze_s[i], force_s[i])
                                 : EQAC_FORCE;
    assign lif[i].step = adapt_strobe && path_live;
    assign lif[i].up = adapt_up[i];
    assign lif[i].force_value = PRESENT ? pick_field(word, HI, LO)
                                        : ABSENT_VALUE;

    eqac_loop #(
      .WIDTH(WIDTH)
    ) u_loop (
      .clock(clock),
      .rst(rst),
      .ce(ce),
      .bus(lif[i].loop)
    );

    assign loop_value[i] = lif[i].value;
  end
endmodule
`default_nettype wire

// file: tb/eqac_assertions.sv
`timescale 1ns/10ps
`default_nettype none
module eqac_checker (
  input wire logic clock,
  input wire logic rst,
  input wire logic ce,
  input wire logic equalizer_type_select,
  input wire logic equalizer_adapt_reset,
  input wire logic offset_loop_freeze,
  input wire logic offset_loop_force,
  input wire logic adapt_strobe,
  input wire logic [eqac_pkg::LOOPS-1:0] adapt_up,
  input wire eqac_pkg::eqac_word_t cfg_word1 [eqac_pkg::LOOPS],
  input wire eqac_pkg::eqac_value_t loop_value [eqac_pkg::LOOPS],
  input wire logic linear_path_active,
  input wire logic adapt_clearing,
  input wire logic restart_pending
);
  import eqac_pkg::*;
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  // Pins held long enough to cross the synchroniser
  logic calm;
  assign calm = !offset_loop_freeze && !offset_loop_force &&
    !equalizer_type_select && !equalizer_adapt_reset;
  sel_linear_a: assert property (
    equalizer_type_select [*4] ##0 !adapt_clearing |-> linear_path_active)
    else $error("linear path not selected");
  sel_feedback_a: assert property (
    !equalizer_type_select [*4] ##0 !adapt_clearing |-> !linear_path_active)
    else $error("feedback path not selected");
  clear_start_a: assert property (
    $rose(equalizer_adapt_reset) |-> ##[1:3] adapt_clearing)
    else $error("adaptation reset not taken");
  clear_zero_a: assert property (
    adapt_clearing [*2] |-> loop_value[0] == 8'h00 && loop_value[20] == 8'h00)
    else $error("loops not cleared");
  pending_keep_a: assert property (
    !equalizer_adapt_reset [*4] ##0 restart_pending |=> restart_pending)
    else $error("restart flag dropped without reset");
  offset_force_a: assert property (
    (offset_loop_force && !adapt_clearing) [*4] |->
      loop_value[0] == {1'b0, cfg_word1[0][15:9]})
    else $error("offset override value wrong");
  freeze_hold_a: assert property (
    (offset_loop_freeze && !offset_loop_force && !adapt_clearing) [*4]
      ##1 !adapt_clearing |-> $stable(loop_value[0]))
    else $error("frozen loop moved");
  step_up_a: assert property (
    calm [*4] ##0 (ce && !adapt_clearing && !linear_path_active && adapt_strobe &&
      adapt_up[0] && loop_value[0] != 8'h7F) |=>
      loop_value[0] == $past(loop_value[0]) + 8'h01)
    else $error("adapt step up wrong");
  floor_hold_a: assert property (
    calm [*4] ##0 (!adapt_clearing && adapt_strobe && !adapt_up[0] &&
      loop_value[0] == 8'h00) |=> loop_value[0] == 8'h00)
    else $error("loop went below zero");
endmodule
bind eqac_top eqac_checker u_eqac_checker (.clock, .rst, .ce,
  .equalizer_type_select, .equalizer_adapt_reset, .offset_loop_freeze,
  .offset_loop_force, .adapt_strobe, .adapt_up, .cfg_word1, .loop_value,
  .linear_path_active, .adapt_clearing, .restart_pending);
`default_nettype wire

// file: tb/eqac_fabric.sv
`timescale 1ns/10ps
`default_nettype none
module eqac_fabric (
  input wire logic clock,
  input wire logic kick,
  input wire logic want_linear,
  output logic equalizer_type_select,
  output logic equalizer_adapt_reset
);
  // Slow on purpose: the device runs a while unreset in the new mode
  initial begin
    equalizer_type_select = 1'b0;
    equalizer_adapt_reset = 1'b0;
    forever begin
      @(posedge clock);
      if (kick || want_linear !== equalizer_type_select) begin
        @(negedge clock);
        equalizer_type_select = want_linear;
        repeat (6) @(negedge clock);
        equalizer_adapt_reset = 1'b1;
        repeat (3) @(negedge clock);
        equalizer_adapt_reset = 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// file: tb/testbench.sv
`timescale 1ns/10ps
`default_nettype none
module testbench;
  import eqac_pkg::*;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic kick = 1'b0;
  logic ce = 1'b1;
  logic want_linear = 1'b0;
  logic sel, ares, adapt_strobe = 1'b0;
  logic [LOOPS-1:0] frz = '0, frc = '0, adapt_up = '0;
  eqac_word_t cfg_word0 [LOOPS], cfg_word1 [LOOPS];
  eqac_value_t loop_value [LOOPS];
  logic linear_path_active, adapt_clearing, restart_pending;
  int errors = 0, n_checks = 0;
  int hi [LOOPS] = '{15, 13, 13, 15, 15, 15, 15, 15, 15, 15, 15, 15, 15, 15,
    15, 15, 15, 13, 13, 13, 13};
  int lo [LOOPS] = '{9, 9, 9, 11, 11, 8, 9, 10, 10, 11, 11, 11, 11, 11, 11,
    11, 11, 9, 9, 9, 9};
  eqac_top u_eqac_top (.clock(clock), .rst(rst), .ce(ce),
    .equalizer_type_select(sel), .equalizer_adapt_reset(ares),
    .offset_loop_freeze(frz[0]), .offset_loop_force(frc[0]),
    .linear_lowfreq_freeze(frz[1]), .linear_lowfreq_force(frc[1]),
    .linear_highfreq_freeze(frz[2]), .linear_highfreq_force(frc[2]),
    .feedback_gain_freeze(frz[3]), .feedback_gain_force(frc[3]),
    .feedback_lowfreq_freeze(frz[4]), .feedback_lowfreq_force(frc[4]),
    .threshold_loop_freeze(frz[5]), .threshold_loop_force(frc[5]),
    .peak_loop_freeze(frz[6]), .peak_loop_force(frc[6]),
    .coeff2_freeze(frz[7]), .coeff2_force(frc[7]),
    .coeff3_freeze(frz[8]), .coeff3_force(frc[8]),
    .coeff4_freeze(frz[9]), .coeff4_force(frc[9]),
    .coeff5_freeze(frz[10]), .coeff5_force(frc[10]),
    .coeff6_freeze(frz[11]), .coeff6_force(frc[11]),
    .coeff7_freeze(frz[12]), .coeff7_force(frc[12]),
    .coeff8_freeze(frz[13]), .coeff8_force(frc[13]),
    .coeff9_freeze(frz[14]), .coeff9_force(frc[14]),
    .coeff10_freeze(frz[15]), .coeff10_force(frc[15]),
    .coeff11_freeze(frz[16]), .coeff11_force(frc[16]),
    .coeff12_freeze(frz[17]), .coeff12_force(frc[17]),
    .coeff13_freeze(frz[18]), .coeff13_force(frc[18]),
    .coeff14_freeze(frz[19]), .coeff14_force(frc[19]),
    .coeff15_freeze(frz[20]), .coeff15_force(frc[20]),
    .cfg_word0(cfg_word0), .cfg_word1(cfg_word1), .gain_cfg_word2(16'h0000),
    .adapt_strobe(adapt_strobe), .adapt_up(adapt_up),
    .loop_value(loop_value), .linear_path_active(linear_path_active),
    .adapt_clearing(adapt_clearing), .restart_pending(restart_pending));
  eqac_fabric u_eqac_fabric (.clock(clock), .kick(kick),
    .want_linear(want_linear), .equalizer_type_select(sel),
    .equalizer_adapt_reset(ares));
  initial begin
    forever #10 clock = ~clock;
  end
  task automatic cyc(input int n);
    repeat (n) @(negedge clock);
  endtask
  task automatic check(input eqac_value_t seen, input eqac_value_t want);
    n_checks++;
    if (seen !== want) begin
      errors++;
      $display("ERROR at %0t: seen %0h expected %0h", $time, seen, want);
    end
  endtask
  // Reads the shared word pair for both low-frequency loops
  function automatic eqac_value_t exp_val(input int i);
    eqac_word_t w;
    w = (i > 16) ? cfg_word0[i] : cfg_word1[(i == 4) ? 1 : i];
    return eqac_value_t'((w >> lo[i]) & ((16'h1 << (hi[i] - lo[i] + 1)) - 1));
  endfunction
  task automatic strobe(input logic [LOOPS-1:0] up, input int n);
    adapt_up = up;
    adapt_strobe = 1'b1;
    cyc(n);
    adapt_strobe = 1'b0;
    cyc(1);
  endtask
  task automatic t_force;
    frc = '1;
    frz = 21'h0AAAAA;
    cyc(5);
    for (int i = 0; i < LOOPS; i++) begin
      check(loop_value[i], exp_val(i));
    end
    frc = '0;
    frz = '0;
    cyc(5);
  endtask
  task automatic t_adapt;
    strobe(21'h000007, 3);
    check(loop_value[0], exp_val(0) + 8'h03);
    check(loop_value[3], exp_val(3) - 8'h03);
    check(loop_value[1], exp_val(1));
    // Enable low must swallow strobes entirely
    ce = 1'b0;
    strobe(21'h000007, 2);
    ce = 1'b1;
    cyc(1);
    check(loop_value[0], exp_val(0) + 8'h03);
    check(loop_value[3], exp_val(3) - 8'h03);
  endtask
  task automatic t_freeze;
    frz = 21'h000001;
    cyc(5);
    strobe('1, 2);
    check(loop_value[0], exp_val(0) + 8'h03);
    check(loop_value[3], exp_val(3) - 8'h01);
    frz = '0;
    cyc(5);
  endtask
  task automatic t_select;
    want_linear = 1'b1;
    cyc(5);
    check({7'h00, linear_path_active}, 8'h01);
    check({7'h00, restart_pending}, 8'h01);
    cyc(20);
    check({7'h00, linear_path_active}, 8'h01);
    check({7'h00, restart_pending}, 8'h00);
    check(loop_value[0], 8'h00);
    strobe('1, 2);
    check(loop_value[1], 8'h02);
    check(loop_value[0], 8'h00);
    strobe('0, 3);
    check(loop_value[1], 8'h00);
    want_linear = 1'b0;
    cyc(25);
    check({7'h00, linear_path_active}, 8'h00);
    strobe('0, 1);
    strobe('1, 1);
    check(loop_value[0], 8'h01);
  endtask
  task end_sim;
    if (errors == 0 && n_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  initial begin
    for (int i = 0; i < LOOPS; i++) begin
      cfg_word0[i] = 16'hA5A5 + eqac_word_t'(i << 11);
      cfg_word1[i] = 16'h5555 + eqac_word_t'(i << 11);
    end
    cyc(3);
    rst = 1'b0;
    kick = 1'b1;
    cyc(1);
    kick = 1'b0;
    cyc(20);
    check({7'h00, adapt_clearing}, 8'h00);
    check(loop_value[20], 8'h00);
    t_force();
    t_adapt();
    t_freeze();
    t_select();
    end_sim();
  end
  // Whole run is well under 400 cycles
  initial begin
    #50us;
    errors++;
    end_sim();
  end
endmodule
`default_nettype wire
